// file: rtl/uhp_pkg.sv
// Package with register map, field positions and enumerations of the host pipe control block.
package uhp_pkg;
   localparam logic [11:0] OFS_CTRL    = 12'h000;
   localparam logic [11:0] OFS_CFG0    = 12'h004;
   localparam logic [11:0] OFS_CFG1    = 12'h008;
   localparam logic [11:0] OFS_CFG2    = 12'h00C;
   localparam logic [11:0] OFS_STA     = 12'h010;
   localparam logic [11:0] OFS_INRQ    = 12'h014;
   localparam logic [11:0] OFS_ERR     = 12'h018;
   localparam logic [11:0] OFS_INT     = 12'h01C;
   localparam logic [11:0] OFS_IEN     = 12'h020;
   localparam logic [11:0] OFS_EVENT   = 12'h024;

   localparam int CTRL_ON     = 0;
   localparam int CTRL_TOGGLE_RESET_REQUEST  = 3;
   localparam int CTRL_IN_REQUEST_MODE = 5;
   localparam int CTRL_FREEZE = 6;

   localparam int CFG1_MEMORY_ALLOCATE  = 1;

   localparam int STA_MEMORY_CONFIG_OK   = 7;
   localparam int STA_OVER    = 6;
   localparam int STA_UNDER   = 5;

   localparam int INT_HANDOFF = 7;
   localparam int INT_NAK     = 6;
   localparam int INT_ACCESS  = 5;
   localparam int INT_PERR    = 4;
   localparam int INT_SETUP   = 3;
   localparam int INT_OUT     = 2;
   localparam int INT_STALL   = 1;
   localparam int INT_IN      = 0;

   localparam int IEN_FLOW    = 7;

   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [7:0] CTRL_RST  = 8'h40;
   localparam logic [1:0] TALLY_MAX = 2'h3;
   localparam logic [2:0] SIZE_MAX1 = 3'h5;
   localparam logic [2:0] SIZE_MAXN = 3'h3;
   localparam logic [3:0] EP_BIG    = 4'h1;

   typedef enum logic [1:0] {
      UHP_KIND_CONTROL = 2'h0,
      UHP_KIND_ISO     = 2'h1,
      UHP_KIND_BULK    = 2'h2,
      UHP_KIND_INTR    = 2'h3
   } uhp_kind_e;

   typedef enum logic [1:0] {
      UHP_TOK_SETUP = 2'h0,
      UHP_TOK_IN    = 2'h1,
      UHP_TOK_OUT   = 2'h2,
      UHP_TOK_RSVD  = 2'h3
   } uhp_token_e;
endpackage : uhp_pkg

// file: rtl/uhp_bank_track.sv
// Bank occupancy and toggle tracker of one pipe.
`timescale 1ns/1ps
module uhp_bank_track (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clear,
   input  wire logic       two_banks,
   input  wire logic       is_in,
   input  wire logic       link_fill,
   input  wire logic       link_drain,
   input  wire logic       sw_release,
   input  wire logic       toggle_reset,
   input  wire logic       toggle_seen,
   input  wire logic       toggle_step,
   output logic      [1:0] busy_bank_count,
   output logic            toggle_value
);
   logic [1:0] busy_r, busy_nxt;
   logic       tgl_r, tgl_nxt;
   logic       cap;
   logic       inc;
   logic       dec;

   always_comb begin
      cap = two_banks ? 1'b1 : 1'b0;
      // For IN the link fills and software frees; for OUT software fills and the link drains.
      inc = is_in ? link_fill : sw_release;
      dec = is_in ? sw_release : link_drain;
      busy_nxt = busy_r;
      if (inc && !dec && busy_r <= {1'b0, cap}) begin
         busy_nxt = busy_r + 2'h1;
      end else if (dec && !inc && busy_r != 2'h0) begin
         busy_nxt = busy_r - 2'h1;
      end
      tgl_nxt = tgl_r;
      if (toggle_reset) begin
         tgl_nxt = 1'b0;
      end else if (is_in && link_fill) begin
         tgl_nxt = toggle_seen;
      end else if (!is_in && toggle_step) begin
         tgl_nxt = ~tgl_r;
      end
      if (clear) begin
         busy_nxt = 2'h0;
         tgl_nxt  = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r <= 2'h0;
         tgl_r  <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
         tgl_r  <= tgl_nxt;
      end
   end

   assign busy_bank_count = busy_r;
   assign toggle_value    = tgl_r;
endmodule : uhp_bank_track

// file: rtl/uhp_in_counter.sv
// Counter of IN requests for counted mode.
`timescale 1ns/1ps
module uhp_in_counter (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       load,
   input  wire logic [7:0] load_value,
   input  wire logic       in_done,
   input  wire logic       counted,
   output logic      [7:0] count,
   output logic            exhausted
);
   logic [7:0] cnt_r, cnt_nxt;
   logic       last_r, last_nxt;

   // The count reaching zero does not stop requests; one more request runs first.
   always_comb begin
      cnt_nxt  = cnt_r;
      last_nxt = 1'b0;
      if (load) begin
         cnt_nxt = load_value;
      end else if (in_done && counted) begin
         if (cnt_r == 8'h00) begin
            last_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r - 8'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r  <= 8'h00;
         last_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         last_r <= last_nxt;
      end
   end

   assign count     = cnt_r;
   assign exhausted = last_r;
endmodule : uhp_in_counter

// file: rtl/uhp_pipe_ctrl.sv
// Host pipe control and status logic with an APB register slave.
// Overview of operation
// RULE1: While frozen no requests are made; clearing the freeze bit resumes them.
// RULE2: Freeze sets when unconfigured, stall, pipe error, count exhausted, reset or enable.
// RULE3: IN request mode set means endless IN requests; clear means counted ones.
// RULE4: Writing one to toggle reset returns toggle to DATA0; bit self-clears.
// RULE5: Pipe on enables the pipe; clearing it disables and resets the pipe.
// RULE6: Transfer kind: 00 control, 01 isochronous, 10 bulk, 11 interrupt.
// RULE7: Token kind: 00 SETUP, 01 IN, 10 OUT, 11 reserved.
// RULE8: Target endpoint is a four-bit number from zero to fifteen.
// RULE9: Size codes 8 to 64 bytes; 128 and 256 only for endpoint 1.
// RULE10: Bank count code 00 is one bank, 01 two banks, others invalid.
// RULE11: Config ok sets on successful allocation and clears only on pipe disable.
// RULE12: Polling interval applies to interrupt pipes only.
// RULE13: Overflow and underflow flags set by hardware, cleared by software; underflow sends ZLP.
// RULE14: Toggle field reports 00 for DATA0 and 01 for DATA1.
// RULE15: Busy bank field reports zero, one or two busy banks.
// RULE16: Counted mode makes count plus one requests, decrementing after each success.
// RULE17: Error tally counts pipe errors and freezes the pipe at three.
// RULE18: Error source flags set by hardware; pipe error clears once sources clear.
// RULE19: Bank handoff sets with bank flags; software clear releases bank, set ignored.
// RULE20: Access allowed drops when FIFO full or empty, on stall or error.
// RULE21: Stall sets the stall flag and freezes; for isochronous it means CRC error.
// RULE22: NAK, setup, OUT and IN flags set by hardware, cleared by software.
// RULE23: Flow error enable gates overflow and underflow interrupts.
// RULE24: Pipe interrupt is high while any flag and its enable are both set.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module uhp_pipe_ctrl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ev_stall,
   input  wire logic        ev_nak,
   input  wire logic        ev_in_fill,
   input  wire logic        ev_in_toggle,
   input  wire logic        ev_out_sent,
   input  wire logic        ev_overflow,
   input  wire logic        ev_underrun,
   input  wire logic        ev_memory_allocate_ok,
   input  wire logic [4:0]  ev_err_src,
   input  wire logic        fifo_full,
   input  wire logic        fifo_empty,
   output logic             req_enable,
   output logic             req_send_zlp,
   output logic             bank_release,
   output logic             pipe_irq
);
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [7:0] cfg0_r, cfg0_nxt;
   logic [7:0] cfg1_r, cfg1_nxt;
   logic [7:0] cfg2_r, cfg2_nxt;
   logic [2:0] sta_r, sta_nxt;
   logic [6:0] err_r, err_nxt;
   logic [7:0] int_r, int_nxt;
   logic [7:0] ien_r, ien_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic        rdy_r, rdy_nxt;
   logic        slverr_r, slverr_nxt;
   logic        req_r, req_nxt;
   logic        zlp_r, zlp_nxt;
   logic        rel_r, rel_nxt;
   logic        irq_r, irq_nxt;
   logic        wr;
   logic        rd_ok;
   logic        hit;
   logic        on_rise;
   logic        pipe_clear;
   logic        sw_handoff_clr;
   logic        err_any;
   logic        is_in;
   logic        is_iso;
   logic        cfg_legal;
   logic        toggle_rst;
   logic        in_last;
   logic [7:0]  inrq_cnt;
   logic [1:0]  busy;
   logic        tgl;
   logic [7:0]  sta_rd;
   logic [7:0]  wd;

   assign wd    = pwdata[7:0];
   // A write lands at the edge where the master sees pready high, never earlier.
   assign wr    = psel && penable && pwrite && rdy_r;
   assign rd_ok = psel && penable && !pwrite && !rdy_r;
   assign hit   = (paddr <= uhp_pkg::OFS_EVENT) && (paddr[1:0] == 2'h0);
   assign is_in  = cfg0_r[5:4] == uhp_pkg::UHP_TOK_IN;                    // [RULE7]
   assign is_iso = cfg0_r[7:6] == uhp_pkg::UHP_KIND_ISO;                  // [RULE6]
   // Large banks only legal for endpoint 1; reserved codes leave the pipe unconfigured.
   assign cfg_legal = (cfg1_r[3:2] <= 2'h1) &&                            // [RULE10]
                      ((cfg1_r[6:4] <= uhp_pkg::SIZE_MAXN) ||
                       (cfg1_r[6:4] <= uhp_pkg::SIZE_MAX1 &&
                        cfg0_r[3:0] == uhp_pkg::EP_BIG));                 // [RULE9] [RULE8]
   assign on_rise    = wr && hit && paddr == uhp_pkg::OFS_CTRL && wd[uhp_pkg::CTRL_ON]
                       && !ctrl_r[uhp_pkg::CTRL_ON];
   assign pipe_clear = !ctrl_r[uhp_pkg::CTRL_ON];                         // [RULE5]
   assign sw_handoff_clr = wr && paddr == uhp_pkg::OFS_INT && !wd[uhp_pkg::INT_HANDOFF]
                           && int_r[uhp_pkg::INT_HANDOFF];                // [RULE19]
   assign toggle_rst = ctrl_r[uhp_pkg::CTRL_TOGGLE_RESET_REQUEST];
   assign err_any    = |err_r[4:0];

   uhp_in_counter u_inrq (
      .pclk       (pclk),
      .presetn    (presetn),
      .load       (wr && paddr == uhp_pkg::OFS_INRQ),
      .load_value (wd),
      .in_done    (ev_in_fill && req_r),
      .counted    (!ctrl_r[uhp_pkg::CTRL_IN_REQUEST_MODE]),                        // [RULE3]
      .count      (inrq_cnt),
      .exhausted  (in_last)                                               // [RULE16]
   );

   uhp_bank_track u_bank (
      .pclk            (pclk),
      .presetn         (presetn),
      .clear           (pipe_clear),
      .two_banks       (cfg1_r[2]),
      .is_in           (is_in),
      .link_fill       (ev_in_fill),
      .link_drain      (ev_out_sent),
      .sw_release      (sw_handoff_clr),
      .toggle_reset    (toggle_rst),                                      // [RULE4]
      .toggle_seen     (ev_in_toggle),
      .toggle_step     (ev_out_sent),
      .busy_bank_count (busy),                                            // [RULE15]
      .toggle_value    (tgl)                                              // [RULE14]
   );

   always_comb begin
      ctrl_nxt = ctrl_r;
      cfg0_nxt = cfg0_r;
      cfg1_nxt = cfg1_r;
      cfg2_nxt = cfg2_r;
      sta_nxt  = sta_r;
      err_nxt  = err_r;
      int_nxt  = int_r;
      ien_nxt  = ien_r;
      // Toggle reset is done in one cycle, so the request bit lives for one cycle.
      ctrl_nxt[uhp_pkg::CTRL_TOGGLE_RESET_REQUEST] = 1'b0;                               // [RULE4]
      if (wr) begin
         unique case (paddr)
            uhp_pkg::OFS_CTRL: begin
               ctrl_nxt = wd & 8'h69;
               ctrl_nxt[uhp_pkg::CTRL_TOGGLE_RESET_REQUEST] = wd[uhp_pkg::CTRL_TOGGLE_RESET_REQUEST];   // [RULE4]
               if (on_rise) begin
                  ctrl_nxt[uhp_pkg::CTRL_FREEZE] = 1'b1;                  // [RULE2]
               end
            end
            uhp_pkg::OFS_CFG0: cfg0_nxt = wd;
            uhp_pkg::OFS_CFG1: cfg1_nxt = wd & 8'h7E;
            uhp_pkg::OFS_CFG2: cfg2_nxt = wd;                             // [RULE12]
            uhp_pkg::OFS_STA: begin
               sta_nxt[1] = sta_r[1] & wd[uhp_pkg::STA_OVER];             // [RULE13]
               sta_nxt[0] = sta_r[0] & wd[uhp_pkg::STA_UNDER];
            end
            uhp_pkg::OFS_ERR: begin
               err_nxt[6:5] = err_r[6:5] & wd[6:5];                       // [RULE17]
               err_nxt[4:0] = err_r[4:0] & wd[4:0];                       // [RULE18]
            end
            uhp_pkg::OFS_INT: begin
               // Only clears take effect; the handoff bit cannot be set by software.
               int_nxt = int_r & (wd | 8'h20);                            // [RULE19] [RULE22]
            end
            uhp_pkg::OFS_IEN: ien_nxt = wd & 8'hDF;
            default: begin
            end
         endcase
      end
      // Hardware sets below win over software clears in the same cycle.
      if (ev_memory_allocate_ok && cfg1_r[uhp_pkg::CFG1_MEMORY_ALLOCATE] && cfg_legal) begin
         sta_nxt[2] = 1'b1;                                               // [RULE11]
      end
      if (ev_overflow) begin
         sta_nxt[1] = 1'b1;                                               // [RULE13]
      end
      if (ev_underrun && !is_in && (is_iso || cfg0_r[7:6] == uhp_pkg::UHP_KIND_INTR)) begin
         sta_nxt[0] = 1'b1;                                               // [RULE13]
      end
      err_nxt[4:0] = err_nxt[4:0] | ev_err_src;                           // [RULE18]
      if (|ev_err_src && err_r[6:5] != uhp_pkg::TALLY_MAX) begin
         err_nxt[6:5] = err_r[6:5] + 2'h1;                                // [RULE17]
      end
      int_nxt[uhp_pkg::INT_PERR] = |err_nxt[4:0];                         // [RULE18]
      if (ev_nak) int_nxt[uhp_pkg::INT_NAK] = 1'b1;                       // [RULE22]
      if (ev_stall) int_nxt[uhp_pkg::INT_STALL] = 1'b1;                   // [RULE21]
      if (ev_in_fill) begin
         int_nxt[uhp_pkg::INT_IN]      = 1'b1;                            // [RULE22]
         int_nxt[uhp_pkg::INT_HANDOFF] = 1'b1;                            // [RULE19]
      end
      if (ev_out_sent) begin
         int_nxt[cfg0_r[5:4] == uhp_pkg::UHP_TOK_SETUP ? uhp_pkg::INT_SETUP
                                                        : uhp_pkg::INT_OUT] = 1'b1;
         int_nxt[uhp_pkg::INT_HANDOFF] = 1'b1;                            // [RULE19]
      end
      int_nxt[uhp_pkg::INT_ACCESS] = !int_nxt[uhp_pkg::INT_STALL] && !int_nxt[uhp_pkg::INT_PERR]
                                     && (is_in ? !fifo_empty : !fifo_full); // [RULE20]
      if (!cfg_legal || !sta_r[2] || ev_stall || |ev_err_src || in_last ||
          (err_nxt[6:5] == uhp_pkg::TALLY_MAX)) begin
         ctrl_nxt[uhp_pkg::CTRL_FREEZE] = 1'b1;                           // [RULE2] [RULE21]
      end
      if (pipe_clear) begin
         // Disabling the pipe resets it and drops the memory configuration.
         ctrl_nxt[uhp_pkg::CTRL_FREEZE] = 1'b1;                           // [RULE5]
         sta_nxt  = 3'h0;                                                 // [RULE11]
         int_nxt  = uhp_pkg::RST_BYTE;
         err_nxt  = 7'h00;
         if (wr && paddr == uhp_pkg::OFS_CTRL) ctrl_nxt = wd & 8'h69 | 8'h40;
      end
   end

   always_comb begin
      rdy_nxt    = psel && penable && !rdy_r;
      slverr_nxt = psel && penable && !rdy_r && !hit;
      rd_nxt     = rd_r;
      sta_rd     = {sta_r, 1'b0, 1'b0, tgl, busy};                        // [RULE14] [RULE15]
      if (rd_ok) begin
         rd_nxt = 32'h0000_0000;
         unique case (paddr)
            uhp_pkg::OFS_CTRL:  rd_nxt[7:0] = ctrl_r;
            uhp_pkg::OFS_CFG0:  rd_nxt[7:0] = cfg0_r;
            uhp_pkg::OFS_CFG1:  rd_nxt[7:0] = cfg1_r;
            uhp_pkg::OFS_CFG2:  rd_nxt[7:0] = cfg2_r;
            uhp_pkg::OFS_STA:   rd_nxt[7:0] = sta_rd;
            uhp_pkg::OFS_INRQ:  rd_nxt[7:0] = inrq_cnt;
            uhp_pkg::OFS_ERR:   rd_nxt[7:0] = {1'b0, err_r};
            uhp_pkg::OFS_INT:   rd_nxt[7:0] = int_r;
            uhp_pkg::OFS_IEN:   rd_nxt[7:0] = ien_r;
            default:            rd_nxt = 32'h0000_0000;
         endcase
      end
      // Polling interval is left to the scheduler; it matters only for interrupt pipes.
      req_nxt = ctrl_r[uhp_pkg::CTRL_ON] && !ctrl_r[uhp_pkg::CTRL_FREEZE] && sta_r[2]; // [RULE1]
      zlp_nxt = ev_underrun && !is_in;                                    // [RULE13]
      rel_nxt = sw_handoff_clr;                                           // [RULE19]
      irq_nxt = |(int_r[6:0] & ien_r[6:0] & 7'h5F) ||
                (ien_r[uhp_pkg::IEN_FLOW] && |sta_r[1:0]);                // [RULE23] [RULE24]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r   <= uhp_pkg::CTRL_RST;
         cfg0_r   <= uhp_pkg::RST_BYTE;
         cfg1_r   <= uhp_pkg::RST_BYTE;
         cfg2_r   <= uhp_pkg::RST_BYTE;
         sta_r    <= 3'h0;
         err_r    <= 7'h00;
         int_r    <= uhp_pkg::RST_BYTE;
         ien_r    <= uhp_pkg::RST_BYTE;
         rd_r     <= 32'h0000_0000;
         rdy_r    <= 1'b0;
         slverr_r <= 1'b0;
         req_r    <= 1'b0;
         zlp_r    <= 1'b0;
         rel_r    <= 1'b0;
         irq_r    <= 1'b0;
      end else begin
         ctrl_r   <= ctrl_nxt;
         cfg0_r   <= cfg0_nxt;
         cfg1_r   <= cfg1_nxt;
         cfg2_r   <= cfg2_nxt;
         sta_r    <= sta_nxt;
         err_r    <= err_nxt;
         int_r    <= int_nxt;
         ien_r    <= ien_nxt;
         rd_r     <= rd_nxt;
         rdy_r    <= rdy_nxt;
         slverr_r <= slverr_nxt;
         req_r    <= req_nxt;
         zlp_r    <= zlp_nxt;
         rel_r    <= rel_nxt;
         irq_r    <= irq_nxt;
      end
   end

   assign prdata       = rd_r;
   assign pready       = rdy_r;
   assign pslverr      = slverr_r;
   assign req_enable   = req_r;
   assign req_send_zlp = zlp_r;
   assign bank_release = rel_r;
   assign pipe_irq     = irq_r;

   chk_freeze_blocks: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
      ctrl_r[uhp_pkg::CTRL_FREEZE] |=> !req_r) else $error("request while frozen");
   chk_stall_freeze: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
      ev_stall |=> ctrl_r[uhp_pkg::CTRL_FREEZE] && int_r[uhp_pkg::INT_STALL])
      else $error("stall did not freeze");
   chk_toggle_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
      ctrl_r[uhp_pkg::CTRL_TOGGLE_RESET_REQUEST] |=> !ctrl_r[uhp_pkg::CTRL_TOGGLE_RESET_REQUEST] && !tgl)
      else $error("toggle reset failed");
   chk_off_resets: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
      !ctrl_r[uhp_pkg::CTRL_ON] |=> !sta_r[2] && busy == 2'h0)
      else $error("disabled pipe kept state");
   chk_tally_freeze: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
      err_r[6:5] == uhp_pkg::TALLY_MAX |-> ctrl_r[uhp_pkg::CTRL_FREEZE])
      else $error("tally at max not frozen");
   chk_perr_follow: assert property (@(posedge pclk) disable iff (!presetn) // [RULE18]
      int_r[uhp_pkg::INT_PERR] == |err_r[4:0]) else $error("pipe error mismatch");
   chk_access_drop: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
      int_r[uhp_pkg::INT_STALL] |-> !int_r[uhp_pkg::INT_ACCESS])
      else $error("access allowed during stall");
   chk_irq_follow: assert property (@(posedge pclk) disable iff (!presetn) // [RULE24]
      (|(int_r[6:0] & ien_r[6:0] & 7'h5F)) |=> pipe_irq) else $error("irq missing");
   chk_in_fill_flags: assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
      ev_in_fill && ctrl_r[uhp_pkg::CTRL_ON] |=> int_r[uhp_pkg::INT_IN]
      && int_r[uhp_pkg::INT_HANDOFF]) else $error("in flags not set");
endmodule : uhp_pipe_ctrl

// file: bench/uhp_usb_dev.sv
// Behavioural model of the USB device on the far side of the pipe.
`timescale 1ns/1ps
module uhp_usb_dev (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       req_enable,
   input  wire logic       go,
   input  wire logic [3:0] code,
   input  wire logic [3:0] lag,
   output logic            ev_stall,
   output logic            ev_nak,
   output logic            ev_in_fill,
   output logic            ev_out_sent,
   output logic            ev_overflow,
   output logic            ev_underrun,
   output logic            ev_memory_allocate_ok,
   output logic      [4:0] ev_err_src
);
   logic [3:0] pend;
   logic [3:0] cnt;
   logic       busy;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         pend <= 4'h0;
      end else if (go) begin
         busy <= 1'b1;
         cnt <= lag;
         pend <= code;
      end else if (busy && cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end else begin
         busy <= 1'b0;
      end
   end
   // Every event is a single-cycle pulse; a lag of zero answers at once.
   always @(posedge pclk) begin
      {ev_stall, ev_nak, ev_in_fill, ev_out_sent} <= 4'h0;
      {ev_overflow, ev_underrun, ev_memory_allocate_ok} <= 3'h0;
      ev_err_src <= 5'h00;
      if (presetn && busy && !go && cnt == 4'h0) begin
         case (pend)
            4'h0: ev_stall <= 1'b1;
            4'h1: ev_nak <= 1'b1;
            // Data only comes back while the pipe is issuing tokens.
            4'h2: ev_in_fill <= req_enable;
            4'h3: ev_out_sent <= 1'b1;
            4'h4: ev_overflow <= 1'b1;
            4'h5: ev_underrun <= 1'b1;
            4'h6: ev_memory_allocate_ok <= 1'b1;
            default: ev_err_src <= 5'h10 >> (pend - 4'h7);
         endcase
      end
   end
endmodule : uhp_usb_dev

// file: bench/uhp_pipe_ctrl_test.sv
// Register-level testbench of the host pipe control block.
`timescale 1ns/1ps
module uhp_pipe_ctrl_test;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, req_enable, req_send_zlp, bank_release, pipe_irq;
   logic        ev_stall, ev_nak, ev_in_fill, ev_out_sent, ev_overflow, ev_underrun;
   logic        ev_memory_allocate_ok;
   logic [4:0]  ev_err_src;
   logic        tgl = 1'b0;
   logic        fifo_full = 1'b0;
   logic        fifo_empty = 1'b1;
   logic        go = 1'b0;
   logic [1:0]  seen = 2'h0;
   logic [3:0]  code = 4'h0;
   logic [3:0]  lag = 4'h0;
   logic [7:0]  q;
   logic        e;
   int          fail_count = 0;
   int          n_compared = 0;

   always #5 pclk = ~pclk;
   always @(posedge pclk) seen <= seen | {req_send_zlp === 1'b1, bank_release === 1'b1};

   uhp_pipe_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ev_stall, .ev_nak, .ev_in_fill, .ev_in_toggle(tgl), .ev_out_sent,
      .ev_overflow, .ev_underrun, .ev_memory_allocate_ok, .ev_err_src, .fifo_full, .fifo_empty,
      .req_enable, .req_send_zlp, .bank_release, .pipe_irq);
   uhp_usb_dev i_dev (.pclk, .presetn, .req_enable, .go, .code, .lag, .ev_stall, .ev_nak,
      .ev_in_fill, .ev_out_sent, .ev_overflow, .ev_underrun, .ev_memory_allocate_ok, .ev_err_src);

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   task automatic cmp8(input string nm, input logic [7:0] x, input logic [7:0] g);
      n_compared++;
      if (g !== x) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, x, g);
      end
   endtask : cmp8

   task automatic cmp1(input string nm, input logic x, input logic g);
      n_compared++;
      if (g !== x) begin
         fail_count++;
         $display("mismatch %s expected %b seen %b", nm, x, g);
      end
   endtask : cmp1

   // The request is held until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         print_verdict();
      end
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] x,
                     input string nm);
      apb(1'b0, a, 8'h00);
      cmp8(nm, x, q & m);
   endtask : rd

   task automatic ev(input logic [3:0] c, input logic [3:0] l, input logic t);
      @(posedge pclk);
      go <= 1'b1;
      code <= c;
      lag <= l;
      tgl <= t;
      @(posedge pclk);
      go <= 1'b0;
      repeat (int'(l) + 4) @(posedge pclk);
   endtask : ev

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(uhp_pkg::OFS_CTRL, 8'hFF, 8'h40, "ctrl");
      rd(uhp_pkg::OFS_STA, 8'hFF, 8'h00, "status");
      rd(uhp_pkg::OFS_INT, 8'hFF, 8'h00, "flags");
      apb(1'b0, 12'h030, 8'h00);
      cmp1("slverr", 1'b1, e);
      // Interrupt IN pipe on endpoint 1 with two 256-byte banks.
      apb(1'b1, uhp_pkg::OFS_CFG0, 8'hD1);
      rd(uhp_pkg::OFS_CFG0, 8'hFF, 8'hD1, "cfg0");
      apb(1'b1, uhp_pkg::OFS_CFG2, 8'h0A);
      rd(uhp_pkg::OFS_CFG2, 8'hFF, 8'h0A, "poll");
      apb(1'b1, uhp_pkg::OFS_CFG1, 8'h56);
      apb(1'b1, uhp_pkg::OFS_CTRL, 8'h01);
      rd(uhp_pkg::OFS_CTRL, 8'hFF, 8'h41, "ctrl");
      ev(4'h6, 4'h0, 1'b0);
      rd(uhp_pkg::OFS_STA, 8'h80, 8'h80, "memory_config_ok");
      cmp1("req", 1'b0, req_enable);
      apb(1'b1, uhp_pkg::OFS_INRQ, 8'h01);
      apb(1'b1, uhp_pkg::OFS_CTRL, 8'h01);
      ev(4'h2, 4'h0, 1'b0);
      cmp1("req", 1'b1, req_enable);
      rd(uhp_pkg::OFS_INRQ, 8'hFF, 8'h00, "inrq");
      rd(uhp_pkg::OFS_INT, 8'hDF, 8'h81, "flags");
      ev(4'h2, 4'h3, 1'b1);
      rd(uhp_pkg::OFS_STA, 8'h8F, 8'h86, "status");
      rd(uhp_pkg::OFS_CTRL, 8'h40, 8'h40, "freeze");
      cmp1("req", 1'b0, req_enable);
      apb(1'b1, uhp_pkg::OFS_CTRL, 8'h49);
      rd(uhp_pkg::OFS_CTRL, 8'h08, 8'h00, "ctrl");
      rd(uhp_pkg::OFS_STA, 8'h0C, 8'h00, "toggle");
      apb(1'b1, uhp_pkg::OFS_INT, 8'h80);
      cmp1("release", 1'b0, seen[0]);
      rd(uhp_pkg::OFS_INT, 8'h01, 8'h00, "in_flag");
      apb(1'b1, uhp_pkg::OFS_INT, 8'h00);
      repeat (3) @(posedge pclk);
      cmp1("release", 1'b1, seen[0]);
      rd(uhp_pkg::OFS_STA, 8'h03, 8'h01, "busy");
      apb(1'b1, uhp_pkg::OFS_IEN, 8'h40);
      ev(4'h1, 4'h0, 1'b0);
      cmp1("irq", 1'b1, pipe_irq);
      apb(1'b1, uhp_pkg::OFS_IEN, 8'h00);
      repeat (2) @(posedge pclk);
      cmp1("irq", 1'b0, pipe_irq);
      ev(4'h4, 4'h0, 1'b0);
      rd(uhp_pkg::OFS_STA, 8'h40, 8'h40, "overflow");
      cmp1("irq", 1'b0, pipe_irq);
      apb(1'b1, uhp_pkg::OFS_IEN, 8'h80);
      repeat (2) @(posedge pclk);
      cmp1("irq", 1'b1, pipe_irq);
      apb(1'b1, uhp_pkg::OFS_STA, 8'h00);
      rd(uhp_pkg::OFS_STA, 8'h40, 8'h00, "overflow");
      fifo_empty <= 1'b0;
      apb(1'b1, uhp_pkg::OFS_CTRL, 8'h21);
      rd(uhp_pkg::OFS_INT, 8'h20, 8'h20, "access");
      for (int i = 0; i < 5; i++) begin
         ev(4'h7 + 4'(i), 4'h0, 1'b0);
         if (i == 2) begin
            rd(uhp_pkg::OFS_ERR, 8'hFF, 8'h7C, "errors");
            rd(uhp_pkg::OFS_CTRL, 8'h40, 8'h40, "freeze");
            rd(uhp_pkg::OFS_INT, 8'h30, 8'h10, "perr");
            apb(1'b1, uhp_pkg::OFS_ERR, 8'h00);
            rd(uhp_pkg::OFS_INT, 8'h10, 8'h00, "perr");
         end
      end
      rd(uhp_pkg::OFS_ERR, 8'hFF, 8'h43, "errors");
      apb(1'b1, uhp_pkg::OFS_ERR, 8'h00);
      apb(1'b1, uhp_pkg::OFS_CTRL, 8'h21);
      ev(4'h0, 4'h0, 1'b0);
      rd(uhp_pkg::OFS_INT, 8'h22, 8'h02, "stall");
      rd(uhp_pkg::OFS_CTRL, 8'h40, 8'h40, "freeze");
      // Same pipe as an interrupt OUT pipe: one bank drained, then one found empty.
      apb(1'b1, uhp_pkg::OFS_CFG0, 8'hE1);
      ev(4'h3, 4'h0, 1'b0);
      rd(uhp_pkg::OFS_INT, 8'h84, 8'h84, "out_flags");
      ev(4'h5, 4'h0, 1'b0);
      cmp1("irq", 1'b1, pipe_irq);
      cmp1("zlp", 1'b1, seen[1]);
      apb(1'b1, uhp_pkg::OFS_CTRL, 8'h00);
      rd(uhp_pkg::OFS_STA, 8'h80, 8'h00, "memory_config_ok");
      print_verdict();
   end
endmodule : uhp_pipe_ctrl_test
